// [logic/asc_pkg.sv]
// shared constants for the converter serial control link
`default_nettype none

package asc_pkg;

  // ----------------------------------------------------------------
  // frame layout and opcodes
  // ----------------------------------------------------------------
  localparam int        FRAME_BITS   = 24;
  localparam logic [4:0] FRAME_COUNT = 5'h18;
  localparam logic [4:0] OTF_COUNT   = 5'h05;
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_READ     = 8'h10;
  localparam logic [7:0] OP_WRITE    = 8'h08;
  localparam logic [7:0] OP_SETBIT   = 8'h18;
  localparam logic [7:0] OP_CLRBIT   = 8'h20;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_GENERAL = 8'h01;
  localparam logic [7:0] ADDR_FORMAT  = 8'h02;
  localparam logic [7:0] ADDR_AVERAGE = 8'h03;
  localparam logic [7:0] ADDR_OPMODE  = 8'h04;
  localparam logic [7:0] ADDR_CHFUNC  = 8'h05;
  localparam logic [7:0] ADDR_PINDIR  = 8'h07;
  localparam logic [7:0] ADDR_DRVTYPE = 8'h09;
  localparam logic [7:0] ADDR_OUTLVL  = 8'h0B;
  localparam logic [7:0] ADDR_INLVL   = 8'h0D;
  localparam logic [7:0] ADDR_SEQCFG  = 8'h10;
  localparam logic [7:0] ADDR_MANUAL  = 8'h11;
  localparam logic [7:0] ADDR_SEQMASK = 8'h12;
  localparam int         REG_SLOTS    = 32;

  localparam logic [7:0] RESET_STATUS = 8'h81;
  localparam logic [7:0] RESET_OTHER  = 8'h00;

  // field positions
  localparam int STATUS_FIXED_BIT = 7;
  localparam int STATUS_SEQ_BIT   = 6;
  localparam int STATUS_BROWN_BIT = 0;
  localparam int GEN_SOFTRST_BIT  = 0;
  localparam int FMT_POLARITY_BIT = 1;
  localparam int FMT_PHASE_BIT    = 0;
  localparam int FMT_APPEND_LO    = 4;
  localparam int SEQ_RUN_BIT      = 4;
  localparam int SEQ_MODE_LO      = 0;
  localparam int AVG_RATIO_LO     = 0;

  localparam logic [1:0] APPEND_CHANNEL = 2'h1;
  localparam logic [1:0] MODE_MANUAL    = 2'h0;
  localparam logic [1:0] MODE_ONFLY     = 2'h2;
  localparam logic [1:0] MODE_AUTO      = 2'h1;

  localparam int NUM_CH  = 8;
  localparam int CH_BITS = 3;

  // ----------------------------------------------------------------
  // host command port and link timing
  // ----------------------------------------------------------------
  localparam logic [7:0] HREG_FRAME  = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [7:0] HREG_RXDATA = 8'h08;
  localparam logic [7:0] HREG_FORMAT = 8'h0C;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int LINK_HALF_NS    = 400;
  localparam int LINK_HALF_CYCLES =
    (LINK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : LINK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [5:0] LINK_EDGES = 6'h30;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_SHIFT = 4'h2,
    HS_TRAIL = 4'h4,
    HS_GAP   = 4'h8
  } asc_host_state_type;

  // software-writable bits of each register, zero when not writable
  function automatic logic [7:0] regWriteMask(input logic [7:0] addr);
    case (addr)
      ADDR_GENERAL: regWriteMask = 8'h06;
      ADDR_FORMAT:  regWriteMask = 8'hB3;
      ADDR_AVERAGE: regWriteMask = 8'h07;
      ADDR_OPMODE,
      ADDR_CHFUNC,
      ADDR_PINDIR,
      ADDR_DRVTYPE,
      ADDR_OUTLVL,
      ADDR_SEQMASK: regWriteMask = 8'hFF;
      ADDR_SEQCFG:  regWriteMask = 8'h13;
      ADDR_MANUAL:  regWriteMask = 8'h0F;
      default:      regWriteMask = 8'h00;
    endcase
  endfunction

  function automatic logic regIsMapped(input logic [7:0] addr);
    regIsMapped = (regWriteMask(addr) != 8'h00) || (addr == ADDR_STATUS) ||
                  (addr == ADDR_INLVL);
  endfunction

endpackage

`default_nettype wire

// [logic/asc_link_if.sv]
// four-wire serial link between host and converter
`default_nettype none

interface asc_link_if;
  logic sclk;
  logic csN;
  logic sdi;
  logic sdo;

  modport device_mp (input sclk, input csN, input sdi, output sdo);
  modport host_mp   (output sclk, output csN, output sdi, input sdo);
endinterface

`default_nettype wire

// [logic/asc_device.sv]
// converter end: frame decoder, register map and channel selection
`default_nettype none

module asc_device
  import asc_pkg::*;
(
  // system
  input  wire logic               clk,
  input  wire logic               rst,
  // serial link
  asc_link_if.device_mp           link,
  // conversion side
  output logic                    convStart,
  output logic [CH_BITS-1:0]      sampleChannel,
  output logic [CH_BITS-1:0]      muxChannel,
  input  wire logic [15:0]        convData,
  input  wire logic [7:0]         gpiLevel
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CH_BITS-1:0] nextChannel(input logic [CH_BITS-1:0] cur,
                                                     input logic [NUM_CH-1:0]  en);
    logic [CH_BITS-1:0] cand;
    logic               found;
    nextChannel = cur;
    found       = 1'b0;
    for (int i = 1; i <= NUM_CH; i++)
    begin
      cand = cur + CH_BITS'(i);
      if (!found && en[cand])
      begin
        nextChannel = cand;
        found       = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] sclkSync_reg;
  logic [1:0] csSync_reg;
  logic [1:0] sdiSync_reg;
  logic [7:0] gpiMeta_reg;
  logic [7:0] gpiSync_reg;
  logic       sclkPrev_reg;
  logic       csPrev_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkSync_reg <= 2'h0;
      csSync_reg   <= 2'h3;
      sdiSync_reg  <= 2'h0;
      gpiMeta_reg  <= 8'h00;
      gpiSync_reg  <= 8'h00;
      sclkPrev_reg <= 1'b0;
      csPrev_reg   <= 1'b1;
    end
    else
    begin
      sclkSync_reg <= {sclkSync_reg[0], link.sclk};
      csSync_reg   <= {csSync_reg[0], link.csN};
      sdiSync_reg  <= {sdiSync_reg[0], link.sdi};
      gpiMeta_reg  <= gpiLevel;
      gpiSync_reg  <= gpiMeta_reg;
      sclkPrev_reg <= sclkSync_reg[1];
      csPrev_reg   <= csSync_reg[1];
    end
  end

  logic [7:0] regFile_reg [0:REG_SLOTS-1];
  logic [7:0] fmtReg;
  logic       cpol;
  logic       cpha;
  logic       inFrame;
  logic       csFall;
  logic       csRise;
  logic       leadEdge;
  logic       trailEdge;
  logic       captureEdge;
  logic       launchEdge;

  assign fmtReg      = regFile_reg[ADDR_FORMAT[4:0]];
  assign cpol        = fmtReg[FMT_POLARITY_BIT];
  assign cpha        = fmtReg[FMT_PHASE_BIT];
  assign inFrame     = ~csSync_reg[1];
  assign csFall      = ~csSync_reg[1] & csPrev_reg;
  assign csRise      = csSync_reg[1] & ~csPrev_reg;
  assign leadEdge    = inFrame & (sclkSync_reg[1] ^ sclkPrev_reg) & (sclkSync_reg[1] ^ cpol);
  assign trailEdge   = inFrame & (sclkSync_reg[1] ^ sclkPrev_reg) & ~(sclkSync_reg[1] ^ cpol);
  assign captureEdge = cpha ? trailEdge : leadEdge;
  assign launchEdge  = cpha ? leadEdge : trailEdge;

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] inShift_reg;
  logic [4:0]            bitCount_reg;

  always_ff @(posedge clk)
  begin
    if (rst || csFall)
    begin
      inShift_reg  <= '0;
      bitCount_reg <= 5'h00;
    end
    else if (captureEdge && bitCount_reg != FRAME_COUNT)
    begin
      inShift_reg  <= {inShift_reg[FRAME_BITS-2:0], sdiSync_reg[1]};
      bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [7:0] cmdOp;
  logic [7:0] cmdAddr;
  logic [7:0] cmdData;
  logic       cmdValid;
  logic       modOp;
  logic [7:0] readValue;
  logic [7:0] newValue;
  logic [7:0] wrMask;
  logic       softReset;
  logic       brownout_reg;
  logic [1:0] modeSel;
  logic       seqRun;
  logic       seqStatus;

  assign cmdOp    = inShift_reg[23:16];
  assign cmdAddr  = inShift_reg[15:8];
  assign cmdData  = inShift_reg[7:0];
  assign cmdValid = csRise && (bitCount_reg == FRAME_COUNT);
  assign modOp    = cmdValid && (cmdOp == OP_WRITE || cmdOp == OP_SETBIT ||
                                 cmdOp == OP_CLRBIT);
  assign wrMask   = regWriteMask(cmdAddr);
  assign modeSel  = regFile_reg[ADDR_SEQCFG[4:0]][SEQ_MODE_LO +: 2];
  assign seqRun   = regFile_reg[ADDR_SEQCFG[4:0]][SEQ_RUN_BIT];
  assign seqStatus = seqRun && (modeSel == MODE_AUTO);

  always_comb
  begin
    readValue = 8'h00;
    if (cmdAddr == ADDR_STATUS)
    begin
      readValue[STATUS_FIXED_BIT] = RESET_STATUS[STATUS_FIXED_BIT];
      readValue[STATUS_SEQ_BIT]   = seqStatus;
      readValue[STATUS_BROWN_BIT] = brownout_reg;
    end
    else if (cmdAddr == ADDR_INLVL)
      readValue = gpiSync_reg;
    else if (wrMask != 8'h00)
      readValue = regFile_reg[cmdAddr[4:0]];
  end

  always_comb
  begin
    if (cmdOp == OP_SETBIT)
      newValue = readValue | cmdData;
    else if (cmdOp == OP_CLRBIT)
      newValue = readValue & ~cmdData;
    else
      newValue = cmdData;
  end

  assign softReset = modOp && (cmdAddr == ADDR_GENERAL) && newValue[GEN_SOFTRST_BIT];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || softReset)
    begin
      for (int i = 0; i < REG_SLOTS; i++)
        regFile_reg[i] <= RESET_OTHER;
    end
    else if (modOp && wrMask != 8'h00)
      regFile_reg[cmdAddr[4:0]] <= (readValue & ~wrMask) | (newValue & wrMask);
  end

  // brown-out: set by either reset, cleared by writing one
  always_ff @(posedge clk)
  begin
    if (rst || softReset)
      brownout_reg <= RESET_STATUS[STATUS_BROWN_BIT];
    else if (modOp && cmdAddr == ADDR_STATUS && cmdOp != OP_CLRBIT &&
             cmdData[STATUS_BROWN_BIT])
      brownout_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // conversion start and channel selection
  // ----------------------------------------------------------------
  logic [4:0] otfWord;
  logic       runPrev_reg;

  assign otfWord = {inShift_reg[3:0], sdiSync_reg[1]};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      convStart     <= 1'b0;
      sampleChannel <= '0;
    end
    else
    begin
      convStart <= csRise;
      if (csRise)
        sampleChannel <= muxChannel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || softReset)
    begin
      muxChannel  <= '0;
      runPrev_reg <= 1'b0;
    end
    else
    begin
      runPrev_reg <= seqRun;
      case (modeSel)
        MODE_MANUAL:
          muxChannel <= regFile_reg[ADDR_MANUAL[4:0]][CH_BITS-1:0];
        MODE_ONFLY:
          if (captureEdge && bitCount_reg == OTF_COUNT - 5'h01)
            muxChannel <= otfWord[CH_BITS-1:0];
        MODE_AUTO:
          if (seqRun && !runPrev_reg)
            muxChannel <= nextChannel(CH_BITS'(NUM_CH - 1),
                                      regFile_reg[ADDR_SEQMASK[4:0]]);
          else if (seqRun && csRise)
            muxChannel <= nextChannel(muxChannel,
                                      regFile_reg[ADDR_SEQMASK[4:0]]);
        default:
          muxChannel <= muxChannel;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-back and result output
  // ----------------------------------------------------------------
  logic                  readPending_reg;
  logic [7:0]            readByte_reg;
  logic [FRAME_BITS-1:0] outShift_reg;
  logic                  sdo_reg;
  logic [FRAME_BITS-1:0] outFrame;
  logic [3:0]            idNibble;
  logic                  avgOn;

  assign avgOn    = regFile_reg[ADDR_AVERAGE[4:0]][AVG_RATIO_LO +: 3] != 3'h0;
  assign idNibble = (fmtReg[FMT_APPEND_LO +: 2] == APPEND_CHANNEL) ?
                    {1'b0, sampleChannel} : 4'h0;

  always_comb
  begin
    if (readPending_reg)
      outFrame = {readByte_reg, 16'h0000};
    else if (avgOn)
      outFrame = {convData, idNibble, 4'h0};
    else
      outFrame = {convData[15:4], idNibble, 8'h00};
  end

  always_ff @(posedge clk)
  begin
    if (rst || softReset)
    begin
      readPending_reg <= 1'b0;
      readByte_reg    <= 8'h00;
    end
    else if (csRise)
    begin
      readPending_reg <= cmdValid && (cmdOp == OP_READ);
      readByte_reg    <= readValue;
    end
    else if (csFall)
      readPending_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst || softReset)
    begin
      outShift_reg <= '0;
      sdo_reg      <= 1'b0;
    end
    else if (csFall)
    begin
      if (cpha)
        outShift_reg <= outFrame;
      else
      begin
        sdo_reg      <= outFrame[FRAME_BITS-1];
        outShift_reg <= {outFrame[FRAME_BITS-2:0], 1'b0};
      end
    end
    else if (launchEdge)
    begin
      sdo_reg      <= outShift_reg[FRAME_BITS-1];
      outShift_reg <= {outShift_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign link.sdo = sdo_reg;

endmodule // asc_device

`default_nettype wire

// [logic/asc_host.sv]
// host end: serial controller driven from a small register port
`default_nettype none

module asc_host
  import asc_pkg::*;
(
  // system
  input  wire logic         clk,
  input  wire logic         rst,
  // serial link
  asc_link_if.host_mp       link,
  // register port
  input  wire logic [7:0]   regAddr,
  input  wire logic [31:0]  regWdata,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output logic [31:0]       regRdata
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  asc_host_state_type    state_reg;
  logic [1:0]            sdoSync_reg;
  logic [FRAME_BITS-1:0] txFrame_reg;
  logic [FRAME_BITS-1:0] txShift_reg;
  logic [FRAME_BITS-1:0] rxFrame_reg;
  logic                  cpol_reg;
  logic                  cpha_reg;
  logic [7:0]            timer_reg;
  logic [5:0]            edgeCount_reg;
  logic                  sclk_reg;
  logic                  csN_reg;
  logic                  sdi_reg;
  logic                  idle;
  logic                  startFrame;
  logic                  timerDone;
  logic                  isCapture;
  logic [7:0]            txOp;
  logic [7:0]            txAddr;
  logic                  badTarget;

  assign idle      = (state_reg == HS_IDLE);
  assign txOp      = regWdata[23:16];
  assign txAddr    = regWdata[15:8];
  // modifying commands to unmapped addresses are refused
  assign badTarget = (txOp == OP_WRITE || txOp == OP_SETBIT || txOp == OP_CLRBIT) &&
                     !regIsMapped(txAddr);
  assign startFrame = idle && regWrite && regAddr == HREG_FRAME && !badTarget;
  assign timerDone  = (timer_reg == 8'h00);
  assign isCapture  = cpha_reg ? edgeCount_reg[0] : ~edgeCount_reg[0];

  always_ff @(posedge clk)
  begin
    if (rst)
      sdoSync_reg <= 2'h0;
    else
      sdoSync_reg <= {sdoSync_reg[0], link.sdo};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpol_reg    <= 1'b0;
      cpha_reg    <= 1'b0;
      txFrame_reg <= '0;
    end
    else if (regWrite && idle)
    begin
      if (regAddr == HREG_FORMAT)
      begin
        cpol_reg <= regWdata[FMT_POLARITY_BIT];
        cpha_reg <= regWdata[FMT_PHASE_BIT];
      end
      if (startFrame)
        txFrame_reg <= regWdata[FRAME_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg     <= HS_IDLE;
      timer_reg     <= 8'h00;
      edgeCount_reg <= 6'h00;
      sclk_reg      <= 1'b0;
      csN_reg       <= 1'b1;
      sdi_reg       <= 1'b0;
      txShift_reg   <= '0;
      rxFrame_reg   <= '0;
    end
    else
    begin
      if (!timerDone)
        timer_reg <= timer_reg - 8'h01;
      unique case (state_reg)
        HS_IDLE:
        begin
          sclk_reg <= cpol_reg;
          if (startFrame)
          begin
            csN_reg       <= 1'b0;
            edgeCount_reg <= 6'h00;
            timer_reg     <= 8'(LINK_HALF_CYCLES - 1);
            state_reg     <= HS_SHIFT;
            if (cpha_reg)
              txShift_reg <= regWdata[FRAME_BITS-1:0];
            else
            begin
              sdi_reg     <= regWdata[FRAME_BITS-1];
              txShift_reg <= {regWdata[FRAME_BITS-2:0], 1'b0};
            end
          end
        end
        HS_SHIFT:
          if (timerDone)
          begin
            sclk_reg      <= ~sclk_reg;
            edgeCount_reg <= edgeCount_reg + 6'h01;
            timer_reg     <= 8'(LINK_HALF_CYCLES - 1);
            if (isCapture)
              rxFrame_reg <= {rxFrame_reg[FRAME_BITS-2:0], sdoSync_reg[1]};
            else
            begin
              sdi_reg     <= txShift_reg[FRAME_BITS-1];
              txShift_reg <= {txShift_reg[FRAME_BITS-2:0], 1'b0};
            end
            if (edgeCount_reg == LINK_EDGES - 6'h01)
              state_reg <= HS_TRAIL;
          end
        HS_TRAIL:
          if (timerDone)
          begin
            csN_reg   <= 1'b1;
            sdi_reg   <= 1'b0;
            timer_reg <= 8'(LINK_HALF_CYCLES - 1);
            state_reg <= HS_GAP;
          end
        HS_GAP:
          if (timerDone)
            state_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.csN  = csN_reg;
  assign link.sdi  = sdi_reg;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      regRdata <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        HREG_FRAME:  regRdata <= {8'h00, txFrame_reg};
        HREG_STATUS: regRdata <= {31'h0000_0000, ~idle};
        HREG_RXDATA: regRdata <= {8'h00, rxFrame_reg};
        HREG_FORMAT: regRdata <= {30'h0000_0000, cpol_reg, cpha_reg};
        default:     regRdata <= 32'h0000_0000;
      endcase
    end
    else
      regRdata <= 32'h0000_0000;
  end

endmodule // asc_host

`default_nettype wire

// [tb/asc_link_props.sv]
// link checker: framing and timing of the serial wires
`default_nettype none

module asc_link_props
(
  // system
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [5:0] edgeCnt;
  logic       sclkPrev;

  // rising clock edges seen in the current frame
  always_ff @(posedge clk)
  begin
    sclkPrev <= sclk;
    if (rst || $fell(csN))
      edgeCnt <= 6'h00;
    else if (sclk && !sclkPrev && !csN)
      edgeCnt <= edgeCnt + 6'h01;
  end

  AST_IDLE_LEVELS: assert property (csN |-> !sclk && !sdi)
    else $error("link not idle while deselected");
  AST_CS_LEAD: assert property ($fell(csN) |-> !sclk [*8])
    else $error("clock moved too soon after select");
  AST_CS_GAP: assert property ($rose(csN) |-> csN [*8])
    else $error("select gap too short");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high phase too short");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("clock low phase too short");
  AST_SDI_HOLD: assert property ($changed(sdi) |=> $stable(sdi) [*8])
    else $error("data moved near capture edge");
  AST_FRAME_LEN: assert property ($rose(csN) |-> edgeCnt == 6'h18)
    else $error("frame not 24 bits");
  AST_FRAME_SPAN: assert property ($fell(csN) |-> ##[380:400] $rose(csN))
    else $error("frame length out of range");
endmodule // asc_link_props

`default_nettype wire

// [tb/adc_spi_register_and_mode_ctrl_tb.sv]
// bench: host and device joined, driven via the host register port
`default_nettype none

module adc_spi_register_and_mode_ctrl_tb
  import asc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic convStart;
  logic [CH_BITS-1:0] sampleChannel;
  logic [CH_BITS-1:0] muxChannel;
  logic [15:0] convData = 16'h0000;
  int n_errors = 0;
  int checks = 0;
  int convCnt = 0;
  logic [31:0] rx;

  asc_link_if link ();
  asc_device i_asc_device (.clk(clk), .rst(rst), .link(link), .convStart(convStart),
    .sampleChannel(sampleChannel), .muxChannel(muxChannel), .convData(convData),
    .gpiLevel(8'h3C));
  asc_host i_asc_host (.clk(clk), .rst(rst), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  asc_link_props i_asc_link_props (.clk(clk), .rst(rst), .sclk(link.sclk), .csN(link.csN),
    .sdi(link.sdi));

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (convStart === 1'b1)
      convCnt++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // one frame, wait for idle, return the received word
  task automatic frame(input logic [23:0] w, output logic [31:0] r);
    int c0;
    logic [31:0] s;
    c0 = convCnt;
    wr(HREG_FRAME, {8'h00, w});
    @(posedge clk);
    for (int i = 0; i < 250; i++)
    begin
      rd(HREG_STATUS, s);
      if (s[0] === 1'b0)
        break;
    end
    chk("frame done", s[0], 1'b0);
    repeat (8) @(posedge clk);
    chk("convStart", convCnt - c0, 1);
    rd(HREG_RXDATA, r);
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
    frame({OP_READ, a, 8'h00}, rx);
    frame(24'h0, rx);
    v = rx[23:16];
  endtask

  task automatic t_reset();
    logic [7:0] v;
    rdReg(ADDR_STATUS, v);
    chk("status", v, 8'h81);
    rdReg(ADDR_SEQCFG, v);
    chk("mode", v, 8'h00);
    rdReg(ADDR_FORMAT, v);
    chk("format", v, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    logic [7:0] v;
    logic [31:0] s;
    frame({OP_WRITE, ADDR_SEQMASK, 8'hA5}, rx);
    frame({OP_WRITE, ADDR_CHFUNC, 8'h5A}, rx);
    frame({OP_READ, ADDR_SEQMASK, 8'h00}, rx);
    frame({OP_READ, ADDR_CHFUNC, 8'h00}, rx);
    chk("mask", rx[23:0], 32'hA50000);
    frame(24'h0, rx);
    chk("chfunc", rx[23:16], 8'h5A);
    wr(HREG_FRAME, {8'h00, OP_WRITE, 8'h06, 8'hFF});
    @(posedge clk);
    rd(HREG_STATUS, s);
    chk("refused", s[0], 1'b0);
    frame({8'h40, ADDR_SEQMASK, 8'h00}, rx);
    frame({OP_WRITE, ADDR_INLVL, 8'hFF}, rx);
    rdReg(ADDR_SEQMASK, v);
    chk("unknown op", v, 8'hA5);
    rdReg(ADDR_INLVL, v);
    chk("input level", v, 8'h3C);
    $display("t_regs done");
  endtask

  task automatic t_manual();
    frame({OP_WRITE, ADDR_MANUAL, 8'h05}, rx);
    chk("old channel", sampleChannel, 3'h0);
    chk("mux", muxChannel, 3'h5);
    frame(24'h0, rx);
    chk("new channel", sampleChannel, 3'h5);
    $display("t_manual done");
  endtask

  task automatic t_result();
    @(posedge clk);
    convData <= 16'h9E37;
    frame(24'h0, rx);
    chk("plain result", rx[23:0], 32'h9E3000);
    frame({OP_WRITE, ADDR_FORMAT, 8'h10}, rx);
    frame({OP_WRITE, ADDR_AVERAGE, 8'h01}, rx);
    chk("id result", rx[23:0], 32'h9E3500);
    frame(24'h0, rx);
    chk("avg result", rx[23:0], 32'h9E3750);
    frame({OP_WRITE, ADDR_FORMAT, 8'h00}, rx);
    frame({OP_WRITE, ADDR_AVERAGE, 8'h00}, rx);
    $display("t_result done");
  endtask

  task automatic t_phase();
    logic [7:0] v;
    frame({OP_WRITE, ADDR_FORMAT, 8'h01}, rx);
    wr(HREG_FORMAT, 32'h0000_0001);
    rdReg(ADDR_FORMAT, v);
    chk("phase one", v, 8'h01);
    frame({OP_WRITE, ADDR_FORMAT, 8'h00}, rx);
    wr(HREG_FORMAT, 32'h0000_0000);
    rdReg(ADDR_FORMAT, v);
    chk("phase zero", v, 8'h00);
    $display("t_phase done");
  endtask

  task automatic t_onfly();
    logic [23:0] w [2] = '{24'h100000, 24'h300000};
    logic [2:0] e [2] = '{3'h2, 3'h6};
    frame({OP_WRITE, ADDR_SEQCFG, 8'h02}, rx);
    foreach (w[i])
    begin
      frame(w[i], rx);
      chk("onfly channel", sampleChannel, e[i]);
    end
    $display("t_onfly done");
  endtask

  task automatic t_auto();
    logic [7:0] v;
    logic [2:0] e [3] = '{3'h2, 3'h6, 3'h2};
    frame({OP_WRITE, ADDR_SEQMASK, 8'h44}, rx);
    frame({OP_WRITE, ADDR_SEQCFG, 8'h11}, rx);
    foreach (e[i])
    begin
      frame(24'h0, rx);
      chk("auto channel", sampleChannel, e[i]);
    end
    rdReg(ADDR_STATUS, v);
    chk("running", v[6], 1'b1);
    frame({OP_WRITE, ADDR_SEQCFG, 8'h01}, rx);
    rdReg(ADDR_STATUS, v);
    chk("stopped", v[6], 1'b0);
    chk("held", muxChannel, 3'h2);
    $display("t_auto done");
  endtask

  task automatic t_softreset();
    logic [7:0] v;
    frame({OP_WRITE, ADDR_STATUS, 8'h01}, rx);
    rdReg(ADDR_STATUS, v);
    chk("cleared", v, 8'h80);
    frame({OP_WRITE, ADDR_GENERAL, 8'h01}, rx);
    rdReg(ADDR_STATUS, v);
    chk("status", v, 8'h81);
    rdReg(ADDR_GENERAL, v);
    chk("reset bit", v, 8'h00);
    rdReg(ADDR_SEQMASK, v);
    chk("mask", v, 8'h00);
    $display("t_softreset done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_manual();
    t_result();
    t_phase();
    t_onfly();
    t_auto();
    t_softreset();
    end_of_test();
  end

  initial
  begin
    #4ms;
    n_errors++;
    end_of_test();
  end
endmodule // adc_spi_register_and_mode_ctrl_tb

`default_nettype wire
